// ### rtl/fps_consts.svh
// What this block does
// - programming only clears bits to zero; only an erase restores ones
// - write and erase are timed in hardware and stall the store port
// - unlock needs first key then second key, any delay between them
// - a wrong or out-of-order key disables writes and erases until reset
// - a flash store to user space before unlock, with no key write that cycle, disables writes and erases until reset
// - every started write or erase returns the lock to locked, or to disabled if a key is written that cycle
// - store write enable steers stores to flash; it holds until cleared
// - flash pages are 512 bytes; erase sets a whole page to all ones
// - erase enable plus write enable: one store erases its whole page
// - pair select zero: each store programs one byte
// - pair select one: two bytes programmed in one write time
// - block is even then odd byte; programming starts on the odd store
// - top 1024 bytes of flash are reserved from user programming
// - key register reads back the two-bit lock state
// - the data byte of an erase store is ignored
// - a flash store above user space raises a flash error reset
`ifndef FPS_CONSTS_SVH
`define FPS_CONSTS_SVH
// register byte offsets
`define FPS_OFF_KEY        8'h00
`define FPS_OFF_STORE_CTL  8'h04
`define FPS_OFF_PREFETCH   8'h08
`define FPS_OFF_TIMING     8'h0c
`define FPS_OFF_STATUS     8'h10
// field positions
`define FPS_BIT_WE         0
`define FPS_BIT_EE         1
`define FPS_BIT_PAIR       0
`define FPS_BIT_RDTIME     4
`define FPS_BIT_BUSY       2
// reset values and keys
`define FPS_TIMING_RST     8'h80
`define FPS_KEY_FIRST      8'ha5
`define FPS_KEY_SECOND     8'hf1
`define FPS_ERASED_BYTE    8'hff
// address limits
`define FPS_USER_TOP       16'hfbff
`define FPS_PAGE_BITS      9
// timing: least times in us, clock in MHz
`define FPS_CLK_MHZ        40
`define FPS_ERASE_TIME_US  10000
`define FPS_WRITE_TIME_US  40
`endif

// ### rtl/fps_pkg.sv
package fps_pkg;
    typedef enum logic [1:0] {
        FPS_LOCKED   = 2'b00,
        FPS_FIRST    = 2'b01,
        FPS_UNLOCKED = 2'b10,
        FPS_DISABLED = 2'b11
    } fps_lock_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  data;
    } fps_store_t;

    typedef struct packed {
        logic        prog;
        logic        erase;
        logic [15:0] addr;
        logic [1:0]  lane_en;
        logic [15:0] clr_mask;
    } fps_cmd_t;
endpackage

// ### rtl/fps_sequencer.sv
`timescale 1ns/100ps
`include "fps_consts.svh"
module fps_sequencer import fps_pkg::*; #(
    parameter int          CNT_W     = 20,
    parameter logic [15:0] USER_TOP  = `FPS_USER_TOP,
    parameter int          ERASE_CYC = `FPS_ERASE_TIME_US * `FPS_CLK_MHZ,
    parameter int          WRITE_CYC = `FPS_WRITE_TIME_US * `FPS_CLK_MHZ
) (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       psel,
    input  wire logic       penable,
    input  wire logic       pwrite,
    input  wire logic [7:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]     prdata,
    output logic            pready,
    output logic            pslverr,
    input  wire logic       st_valid,
    input  wire fps_store_t st_req,
    output logic            st_ready,
    output logic            xram_we,
    output fps_store_t      xram_req,
    output fps_cmd_t        flash_cmd,
    output logic            flash_busy,
    output logic            flash_error_reset,
    output logic            read_time_select
);
    // ==========================================================
    // register bus
    logic        wr_acc;
    logic        rd_setup;
    logic        mapped;
    logic        key_wr;
    logic [1:0]  store_ctl_reg;
    logic        pair_reg;
    logic        rdtime_reg;
    fps_lock_t   lock_reg;
    logic [31:0] rd_next;

    assign wr_acc = psel && penable && pwrite;
    assign rd_setup = psel && !penable && !pwrite;
    assign key_wr = wr_acc && (paddr == `FPS_OFF_KEY);
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign read_time_select = rdtime_reg;

    // address decode and read mux
    always_comb begin
        mapped = 1'b1;
        rd_next = 32'h0;
        if (paddr == `FPS_OFF_KEY) begin
            rd_next[1:0] = lock_reg;
        end else if (paddr == `FPS_OFF_STORE_CTL) begin
            rd_next[1:0] = store_ctl_reg;
        end else if (paddr == `FPS_OFF_PREFETCH) begin
            rd_next[`FPS_BIT_PAIR] = pair_reg;
        end else if (paddr == `FPS_OFF_TIMING) begin
            rd_next[7:0] = `FPS_TIMING_RST;
            rd_next[`FPS_BIT_RDTIME] = rdtime_reg;
        end else if (paddr == `FPS_OFF_STATUS) begin
            rd_next[1:0] = lock_reg;
            rd_next[`FPS_BIT_BUSY] = flash_busy;
        end else begin
            mapped = 1'b0;
        end
    end

    // read data captured in setup phase
    always_ff @(posedge clk) begin
        if (rst) begin
            prdata <= 32'h0;
        end else if (rd_setup) begin
            prdata <= rd_next;
        end
    end

    // control registers; write enable holds until software clears it
    always_ff @(posedge clk) begin
        if (rst) begin
            store_ctl_reg <= 2'b00;
            pair_reg <= 1'b0;
            rdtime_reg <= 1'b0;
        end else if (wr_acc) begin
            if (paddr == `FPS_OFF_STORE_CTL) begin
                store_ctl_reg <= pwdata[1:0];
            end else if (paddr == `FPS_OFF_PREFETCH) begin
                pair_reg <= pwdata[`FPS_BIT_PAIR];
            end else if (paddr == `FPS_OFF_TIMING) begin
                rdtime_reg <= pwdata[`FPS_BIT_RDTIME];
            end
        end
    end

    // ==========================================================
    // store classification
    logic        we;
    logic        ee;
    logic        take;
    logic        fl_store;
    logic        illegal;
    logic        start_op;
    logic        start_erase;
    logic        start_prog;
    logic [7:0]  even_reg;
    logic [CNT_W-1:0] cnt_reg;

    assign we = store_ctl_reg[`FPS_BIT_WE];
    assign ee = store_ctl_reg[`FPS_BIT_EE];
    assign st_ready = !flash_busy;
    assign take = st_valid && st_ready;
    assign fl_store = take && we;
    assign illegal = fl_store && (st_req.addr > USER_TOP);
    assign start_op = fl_store && !illegal && (lock_reg == FPS_UNLOCKED);
    assign start_erase = start_op && ee;
    assign start_prog = start_op && !ee && (!pair_reg || st_req.addr[0]);

    // ==========================================================
    // lock and key state machine
    always_ff @(posedge clk) begin
        if (rst) begin
            lock_reg <= FPS_LOCKED;
        end else if (lock_reg == FPS_DISABLED) begin
            lock_reg <= FPS_DISABLED;
        end else if (key_wr) begin
            case (lock_reg)
                FPS_LOCKED: begin
                    if (pwdata[7:0] == `FPS_KEY_FIRST) begin
                        lock_reg <= FPS_FIRST;
                    end else begin
                        lock_reg <= FPS_DISABLED;
                    end
                end
                FPS_FIRST: begin
                    if (pwdata[7:0] == `FPS_KEY_SECOND) begin
                        lock_reg <= FPS_UNLOCKED;
                    end else begin
                        lock_reg <= FPS_DISABLED;
                    end
                end
                default: begin
                    lock_reg <= FPS_DISABLED;
                end
            endcase
        end else if (fl_store && !illegal) begin
            if (lock_reg == FPS_UNLOCKED) begin
                lock_reg <= FPS_LOCKED;
            end else begin
                lock_reg <= FPS_DISABLED;
            end
        end
    end

    // ==========================================================
    // even byte buffer for block mode
    always_ff @(posedge clk) begin
        if (rst) begin
            even_reg <= `FPS_ERASED_BYTE;
        end else if (start_prog || start_erase) begin
            even_reg <= `FPS_ERASED_BYTE;
        end else if (start_op && pair_reg && !st_req.addr[0]) begin
            even_reg <= st_req.data;
        end
    end

    // ==========================================================
    // flash command and busy timer
    always_ff @(posedge clk) begin
        if (rst) begin
            flash_cmd <= '0;
        end else begin
            flash_cmd.prog <= start_prog;
            flash_cmd.erase <= start_erase;
            if (start_erase) begin
                // page base; store data is ignored
                flash_cmd.addr <= {st_req.addr[15:`FPS_PAGE_BITS],
                                   {`FPS_PAGE_BITS{1'b0}}};
                flash_cmd.lane_en <= 2'b11;
                flash_cmd.clr_mask <= 16'h0000;
            end else if (start_prog && pair_reg) begin
                flash_cmd.addr <= {st_req.addr[15:1], 1'b0};
                flash_cmd.lane_en <= 2'b11;
                flash_cmd.clr_mask <= ~{st_req.data, even_reg};
            end else if (start_prog) begin
                flash_cmd.addr <= st_req.addr;
                flash_cmd.lane_en <= st_req.addr[0] ? 2'b10 : 2'b01;
                flash_cmd.clr_mask <= ~{st_req.data, st_req.data};
            end
        end
    end

    // busy counter loads the operation time
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_reg <= '0;
            flash_busy <= 1'b0;
        end else if (start_erase) begin
            cnt_reg <= CNT_W'(ERASE_CYC - 1);
            flash_busy <= 1'b1;
        end else if (start_prog) begin
            cnt_reg <= CNT_W'(WRITE_CYC - 1);
            flash_busy <= 1'b1;
        end else if (cnt_reg != '0) begin
            cnt_reg <= cnt_reg - 1'b1;
        end else begin
            flash_busy <= 1'b0;
        end
    end

    // ==========================================================
    // data memory steering and flash error
    always_ff @(posedge clk) begin
        if (rst) begin
            xram_we <= 1'b0;
            xram_req <= '0;
            flash_error_reset <= 1'b0;
        end else begin
            xram_we <= take && !we;
            if (take && !we) begin
                xram_req <= st_req;
            end
            flash_error_reset <= illegal;
        end
    end

    // ==========================================================
    // busy length tracker for the duration checks
    logic [CNT_W-1:0] busy_len_reg;
    logic             busy_erase_reg;

    // counts the busy cycles of the running operation
    always_ff @(posedge clk) begin
        if (rst) begin
            busy_len_reg <= '0;
            busy_erase_reg <= 1'b0;
        end else if (start_erase || start_prog) begin
            busy_len_reg <= '0;
            busy_erase_reg <= start_erase;
        end else if (flash_busy) begin
            busy_len_reg <= busy_len_reg + 1'b1;
        end
    end

    // ==========================================================
    // checks
    a_disabled_sticky: assert property (@(posedge clk) disable iff (rst)
        lock_reg == FPS_DISABLED |=> lock_reg == FPS_DISABLED)
        else $error("disabled lock left before reset");
    a_early_store: assert property (@(posedge clk) disable iff (rst)
        fl_store && !illegal && !key_wr && lock_reg != FPS_UNLOCKED
        |=> lock_reg == FPS_DISABLED && !flash_cmd.prog)
        else $error("store before unlock not disabled");
    a_relock_op: assert property (@(posedge clk) disable iff (rst)
        start_op && !key_wr |=> lock_reg == FPS_LOCKED)
        else $error("lock not restored after operation");
    a_key_first: assert property (@(posedge clk) disable iff (rst)
        key_wr && lock_reg == FPS_LOCKED && pwdata[7:0] == `FPS_KEY_FIRST
        |=> lock_reg == FPS_FIRST)
        else $error("first key not accepted");
    a_key_second: assert property (@(posedge clk) disable iff (rst)
        key_wr && lock_reg == FPS_FIRST && pwdata[7:0] == `FPS_KEY_SECOND
        |=> lock_reg == FPS_UNLOCKED)
        else $error("second key not accepted");
    a_key_wrong: assert property (@(posedge clk) disable iff (rst)
        key_wr && lock_reg == FPS_FIRST && pwdata[7:0] != `FPS_KEY_SECOND
        |=> lock_reg == FPS_DISABLED)
        else $error("wrong second key not disabled");
    a_erase_busy: assert property (@(posedge clk) disable iff (rst)
        start_erase |=> flash_cmd.erase && flash_busy ##1 flash_busy[*7])
        else $error("erase busy too short");
    a_erase_start: assert property (@(posedge clk) disable iff (rst)
        start_op && ee |=> flash_cmd.erase && !flash_cmd.prog && flash_cmd.lane_en == 2'b11)
        else $error("erase store did not start an erase");
    a_erase_len: assert property (@(posedge clk) disable iff (rst)
        $fell(flash_busy) && busy_erase_reg |-> busy_len_reg == CNT_W'(ERASE_CYC))
        else $error("erase busy length wrong");
    a_write_len: assert property (@(posedge clk) disable iff (rst)
        $fell(flash_busy) && !busy_erase_reg |-> busy_len_reg == CNT_W'(WRITE_CYC))
        else $error("write busy length wrong");
    a_stall: assert property (@(posedge clk) disable iff (rst)
        flash_busy |-> !st_ready)
        else $error("store accepted while busy");
    a_steer_xram: assert property (@(posedge clk) disable iff (rst)
        take && !we |=> xram_we && !flash_cmd.prog && !flash_cmd.erase)
        else $error("store not steered to data memory");
    a_xram_data: assert property (@(posedge clk) disable iff (rst)
        take && !we |=> xram_req == $past(st_req))
        else $error("data memory store altered");
    a_byte_prog: assert property (@(posedge clk) disable iff (rst)
        start_op && !ee && !pair_reg
        |=> flash_cmd.prog && flash_cmd.addr == $past(st_req.addr))
        else $error("byte store did not program");
    a_pair_prog: assert property (@(posedge clk) disable iff (rst)
        start_prog && pair_reg |=> flash_cmd.lane_en == 2'b11 && !flash_cmd.addr[0])
        else $error("block write not on both lanes");
    a_even_hold: assert property (@(posedge clk) disable iff (rst)
        start_op && pair_reg && !ee && !st_req.addr[0] |=> !flash_cmd.prog)
        else $error("even store started programming");
    a_error_reset: assert property (@(posedge clk) disable iff (rst)
        fl_store && st_req.addr > USER_TOP |=> flash_error_reset && !flash_cmd.prog)
        else $error("reserved store without error reset");
    a_page_base: assert property (@(posedge clk) disable iff (rst)
        flash_cmd.erase |-> flash_cmd.addr[8:0] == 9'h0 && flash_cmd.clr_mask == 16'h0)
        else $error("erase not page aligned");
    a_write_time: assert property (@(posedge clk) disable iff (rst)
        start_prog |=> cnt_reg == CNT_W'(WRITE_CYC - 1) && flash_busy)
        else $error("write time not loaded");
    a_lock_read: assert property (@(posedge clk) disable iff (rst)
        rd_setup && paddr == `FPS_OFF_KEY |=> prdata[1:0] == $past(lock_reg))
        else $error("key register read wrong lock state");
endmodule

// ### dv/fps_cpu_model.sv
`timescale 1ns/100ps
// ==========================================================
// cpu store port: holds one store until the block takes it
module fps_cpu_model import fps_pkg::*; (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       go,
    input  wire fps_store_t req,
    input  wire logic       st_ready,
    output logic            st_valid,
    output fps_store_t      st_req,
    output logic            done
);
    // request held until taken, bus scrambled after release
    always_ff @(posedge clk) begin
        if (rst) begin
            st_valid <= 1'b0;
            st_req   <= '0;
            done     <= 1'b0;
        end else begin
            done <= 1'b0;
            if (st_valid && st_ready) begin
                st_valid <= 1'b0;
                st_req   <= ~st_req;  // released bus shows no stale value
                done     <= 1'b1;
            end else if (go && !st_valid) begin
                st_valid <= 1'b1;
                st_req   <= req;
            end
        end
    end
endmodule

// ### dv/flash_program_erase_sequencer_tb.sv
`timescale 1ns/100ps
module flash_program_erase_sequencer_tb import fps_pkg::*;;
    localparam int WCYC = 6;
    localparam int ECYC = 20;
    logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, go = 0;
    logic [7:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rdata;
    logic pready, pslverr, rerr, st_valid, st_ready, xram_we, flash_busy, done;
    logic flash_error_reset, read_time_select;
    fps_store_t st_req, xram_req, last_x, req = '0;
    fps_cmd_t flash_cmd, last_cmd;
    int bad_count = 0, cmp_count = 0, n_cmd = 0, n_x = 0, n_err = 0, blen = 0, last_blen = 0;
    int c;
    // ======================================================
    // design, cpu model and clock
    fps_sequencer #(.CNT_W(20), .ERASE_CYC(ECYC), .WRITE_CYC(WCYC)) dut (.clk(clk), .rst(rst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .st_valid(st_valid),
        .st_req(st_req), .st_ready(st_ready), .xram_we(xram_we), .xram_req(xram_req),
        .flash_cmd(flash_cmd), .flash_busy(flash_busy), .flash_error_reset(flash_error_reset),
        .read_time_select(read_time_select));
    fps_cpu_model cpu (.clk(clk), .rst(rst), .go(go), .req(req), .st_ready(st_ready),
        .st_valid(st_valid), .st_req(st_req), .done(done));
    initial begin
        forever #12.5 clk = ~clk;
    end
    // captures pulses and busy length
    always @(posedge clk) begin
        if (flash_cmd.prog === 1'b1 || flash_cmd.erase === 1'b1) begin
            last_cmd <= flash_cmd;
            n_cmd <= n_cmd + 1;
        end
        if (xram_we === 1'b1) begin
            last_x <= xram_req;
            n_x <= n_x + 1;
        end
        if (flash_error_reset === 1'b1) n_err <= n_err + 1;
        if (flash_busy === 1'b1) blen <= blen + 1;
        else if (blen != 0) begin
            last_blen <= blen;
            blen <= 0;
        end
    end
    // ======================================================
    // bus, store and compare tasks
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic pulse_rst();
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
    endtask
    task automatic unlock();
        apb(1'b1, 8'h00, 32'ha5);
        apb(1'b1, 8'h00, 32'hf1);
    endtask
    task automatic store(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        go <= 1'b1;
        req <= {a, d};
        @(posedge clk);
        go <= 1'b0;
        while (done !== 1'b1) begin
            @(posedge clk);
        end
        repeat (2) @(posedge clk);
        while (flash_busy === 1'b1) begin
            @(posedge clk);
        end
        repeat (2) @(posedge clk);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic lock_is(input logic [31:0] exp);
        apb(1'b0, 8'h00, 32'h0);
        chk(rdata, exp);
    endtask
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // ======================================================
    // scenarios
    task automatic t_regs();
        lock_is(32'h0);
        apb(1'b0, 8'h0c, 32'h0);
        chk(rdata, 32'h80);
        apb(1'b1, 8'h0c, 32'h90);
        @(posedge clk);
        chk(read_time_select, 1'b1);
        apb(1'b0, 8'h40, 32'h0);
        chk(rerr, 1'b1);
        $display("test regs done");
    endtask
    task automatic t_byte();
        apb(1'b1, 8'h04, 32'h1);
        unlock();
        lock_is(32'h2);
        c = n_cmd;
        store(16'h0122, 8'h3c);
        chk(n_cmd - c, 1);
        chk({last_cmd.prog, last_cmd.lane_en, last_cmd.addr}, {3'b101, 16'h0122});
        chk(last_cmd.clr_mask, 16'hc3c3);
        chk(last_blen, WCYC);
        lock_is(32'h0);
        $display("test byte done");
    endtask
    task automatic t_erase();
        apb(1'b1, 8'h04, 32'h3);
        unlock();
        store(16'h0345, 8'h00);
        chk({last_cmd.erase, last_cmd.lane_en, last_cmd.addr}, {3'b111, 16'h0200});
        chk(last_cmd.clr_mask, 16'h0000);
        chk(last_blen, ECYC);
        $display("test erase done");
    endtask
    task automatic t_pair();
        apb(1'b1, 8'h08, 32'h1);
        apb(1'b1, 8'h04, 32'h1);
        unlock();
        c = n_cmd;
        store(16'h0410, 8'h12);
        chk(n_cmd - c, 0);
        lock_is(32'h0);
        unlock();
        store(16'h0411, 8'h34);
        chk(n_cmd - c, 1);
        chk({last_cmd.lane_en, last_cmd.addr}, {2'b11, 16'h0410});
        chk(last_cmd.clr_mask, 16'hcbed);
        chk(last_blen, WCYC);
        apb(1'b1, 8'h08, 32'h0);
        $display("test pair done");
    endtask
    task automatic t_reserved();
        unlock();
        c = n_err;
        store(16'hfc00, 8'hff);
        chk(n_err - c, 1);
        apb(1'b1, 8'h04, 32'h0);
        store(16'h1234, 8'h5a);
        chk(last_x, {16'h1234, 8'h5a});
        $display("test reserved done");
    endtask
    task automatic t_lockout();
        pulse_rst();
        lock_is(32'h0);
        apb(1'b1, 8'h00, 32'ha5);
        apb(1'b1, 8'h00, 32'h33);
        lock_is(32'h3);
        unlock();
        lock_is(32'h3);
        apb(1'b1, 8'h04, 32'h1);
        c = n_cmd;
        store(16'h0100, 8'h00);
        chk(n_cmd - c, 0);
        pulse_rst();
        lock_is(32'h0);
        apb(1'b1, 8'h04, 32'h1);
        store(16'h0102, 8'h00);
        lock_is(32'h3);
        unlock();
        lock_is(32'h3);
        $display("test lockout done");
    endtask
    // ======================================================
    // main sequence and watchdog
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_byte();
        t_erase();
        t_pair();
        t_reserved();
        t_lockout();
        stop_test();
    end
    initial begin
        #(25 * 5000);
        bad_count++;
        stop_test();
    end
endmodule
